// ---- sat_tx.sv ----
// serial transmitter: registers, framing, shifter and pin control
// Function
// - character has 8 or 9 data bits; ninth bit from control three
// - data buffer is write-only holding stage before the shifter
// - empty flag clears on status read followed by data write
// - transmission begins with an all-ones preamble before data
// - start bit zero sits in least significant shifter position
// - stop bit one sits in most significant shifter position
// - empty flag sets when buffer hands byte to shifter
// - empty flag with its enable raises transmit interrupt
// - output idles high when no character is shifting
// - clearing module enable returns pins to general-purpose control
// - baud source chosen by bit in system config two register
// - transmitter and receiver share one baud generator; here it drives the transmitter only
// - baud generator offers 32 selectable rates
// - transmitter has its own enable, independent of receiver
// - send-break sends zero characters; ends with at least one high bit
// - inversion bit inverts every transmitted bit including idle
// - complete flag sets when all empty; may request interrupt
// - disable then enable during character queues one idle character
`timescale 1ns/1ns
`include "sat_consts.svh"
module sat_tx #(
    parameter int BASE_DIV = 68
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire sat_pkg::sat_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output sat_pkg::sat_byte_t o_rdata,
    input wire logic i_ext_baud_clk,
    output logic o_serial_out_pin,
    output logic o_serial_out_oe,
    output logic o_pin_owned,
    output logic o_rx_enable,
    output logic o_tx_irq
);
    import sat_pkg::*;
    initial begin
        if (BASE_DIV < 1) $error("sat_tx: BASE_DIV must be >= 1");
        // the slowest rate multiplies the base divider by 64
        if (BASE_DIV * 64 > (1 << `SAT_BAUD_CNT_W)) begin
            $error("sat_tx: BASE_DIV too large for the baud counter");
        end
    end
    sat_baud_if bif();
    sat_byte_t ctrl1_reg, ctrl2_reg, ctrl3_reg, baud_reg, syscfg_reg;
    sat_byte_t data_reg;
    sat_byte_t rdata_reg;
    logic data_full_reg;
    logic empty_reg;
    logic done_reg;
    logic status_seen_reg;
    logic queue_idle_reg;
    logic tail_high_reg;
    logic [`SAT_FRAME_W-1:0] shift_reg;
    logic [3:0] bits_reg;
    logic out_reg;
    sat_state_t state_reg;
    logic en_mod, en_tx, len9, inv, brk, wr_data, rd_status, load;
    logic [3:0] char_bits;
    logic wr_ctrl_two;
    logic [`SAT_FRAME_W-1:0] frame_word;
    sat_byte_t status_word;
    assign en_mod = ctrl1_reg[`SAT_C1_ENABLE];
    assign en_tx = ctrl2_reg[`SAT_C2_TXEN] & en_mod;
    assign len9 = ctrl1_reg[`SAT_C1_LEN9];
    assign inv = ctrl1_reg[`SAT_C1_INVERT];
    assign brk = ctrl2_reg[`SAT_C2_BREAK];
    assign wr_data = i_wr && (i_addr == `SAT_OFS_DATA);
    assign rd_status = i_rd && (i_addr == `SAT_OFS_STATUS_ONE);
    assign wr_ctrl_two = i_wr && (i_addr == `SAT_OFS_CTRL_TWO);
    // ************************************************************
    // character length: idle and break characters last as long as
    // start and data bits together, one slot short of a whole frame
    // ************************************************************
    always_comb begin
        char_bits = `SAT_CHAR_BITS_8;
        if (len9) begin
            char_bits = `SAT_CHAR_BITS_9;
        end
    end
    // ************************************************************
    // frame word: stop in msb, ninth bit or second stop, data, start
    // ************************************************************
    always_comb begin
        frame_word = {1'b1, 1'b1, data_reg, 1'b0};
        if (len9) begin
            frame_word[`SAT_FRAME_W-2] = ctrl3_reg[`SAT_C3_NINTH];
        end
    end
    // ************************************************************
    // baud generator, private to the transmitter; no port carries its tick
    // ************************************************************
    // a rate change retimes the transmitter; change it while it is idle
    assign bif.rate_sel = baud_reg[`SAT_BAUD_SEL_W-1:0];
    assign bif.src_sel = syscfg_reg[`SAT_CFG_BAUDSRC];
    sat_baud_gen #(.BASE_DIV(BASE_DIV)) u_baud (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ext_clk(i_ext_baud_clk),
        .bif(bif)
    );
    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl1_reg <= `SAT_RST_BYTE;
            ctrl2_reg <= `SAT_RST_BYTE;
            ctrl3_reg <= `SAT_RST_BYTE;
            baud_reg <= `SAT_RST_BYTE;
            syscfg_reg <= `SAT_RST_BYTE;
        end else if (i_wr) begin
            case (i_addr)
                `SAT_OFS_CTRL_ONE: ctrl1_reg <= i_wdata;
                `SAT_OFS_CTRL_TWO: ctrl2_reg <= i_wdata;
                `SAT_OFS_CTRL_THREE: ctrl3_reg <= i_wdata;
                `SAT_OFS_BAUD: baud_reg <= i_wdata;
                `SAT_OFS_SYSCFG_TWO: syscfg_reg <= i_wdata;
                default: ;
            endcase
        end
    end
    // ************************************************************
    // holding buffer and empty flag
    // ************************************************************
    // buffer is write-only: nothing reads it back on the bus
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            data_reg <= `SAT_RST_BYTE;
        end else if (wr_data) begin
            data_reg <= i_wdata;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            status_seen_reg <= 1'b0;
        end else if (rd_status && empty_reg) begin
            status_seen_reg <= 1'b1;
        end else if (wr_data) begin
            status_seen_reg <= 1'b0;
        end
    end
    // a write without the prior status read is stored but not queued
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            empty_reg <= 1'b1;
            data_full_reg <= 1'b0;
        end else if (load) begin
            empty_reg <= 1'b1;
            data_full_reg <= 1'b0;
        end else if (wr_data && status_seen_reg) begin
            empty_reg <= 1'b0;
            data_full_reg <= 1'b1;
        end
    end
    // ************************************************************
    // transmit sequencer
    // ************************************************************
    // the byte leaves the buffer only as the preamble ends, so the
    // empty flag cannot invite a write that would overwrite it
    assign load = (state_reg == SAT_PREAMBLE) && (bits_reg == 4'h0)
                  && bif.tick && en_mod && data_full_reg && !brk;
    // enable turned off and on again while a frame shifts asks for one
    // idle character; cleared once that character has begun
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            queue_idle_reg <= 1'b0;
        end else if (wr_ctrl_two && state_reg == SAT_SHIFT && !en_tx
                     && i_wdata[`SAT_C2_TXEN]) begin
            queue_idle_reg <= 1'b1;
        end else if (state_reg == SAT_PREAMBLE) begin
            queue_idle_reg <= 1'b0;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= SAT_IDLE;
            shift_reg <= '1;
            bits_reg <= 4'h0;
            tail_high_reg <= 1'b0;
            out_reg <= 1'b1;
        // dropping the module enable abandons any frame and frees the pin
        end else if (!en_mod) begin
            state_reg <= SAT_IDLE;
            shift_reg <= '1;
            bits_reg <= 4'h0;
            tail_high_reg <= 1'b0;
            out_reg <= 1'b1;
        end else if (bif.tick) begin
            case (state_reg)
                SAT_IDLE: begin
                    out_reg <= 1'b1;
                    tail_high_reg <= 1'b0;
                    if (en_tx && brk && !tail_high_reg) begin
                        state_reg <= SAT_BREAK;
                        shift_reg <= '0;
                        bits_reg <= char_bits - `SAT_ONE_CNT;
                        out_reg <= 1'b0;
                    end else if (en_tx && (data_full_reg || queue_idle_reg)) begin
                        state_reg <= SAT_PREAMBLE;
                        shift_reg <= '1;
                        bits_reg <= char_bits - `SAT_ONE_CNT;
                    end
                end
                SAT_PREAMBLE: begin
                    out_reg <= 1'b1;
                    if (bits_reg == 4'h0) begin
                        state_reg <= SAT_IDLE;
                    end else begin
                        bits_reg <= bits_reg - `SAT_ONE_CNT;
                    end
                    if (load) begin
                        state_reg <= SAT_SHIFT;
                        shift_reg <= frame_word;
                        bits_reg <= char_bits + `SAT_ONE_CNT;
                    end
                end
                SAT_SHIFT: begin
                    out_reg <= shift_reg[0];
                    shift_reg <= {1'b1, shift_reg[`SAT_FRAME_W-1:1]};
                    if (bits_reg == 4'h0) begin
                        state_reg <= SAT_IDLE;
                        out_reg <= 1'b1;
                    end else begin
                        bits_reg <= bits_reg - `SAT_ONE_CNT;
                    end
                end
                SAT_BREAK: begin
                    out_reg <= 1'b0;
                    if (bits_reg == 4'h0) begin
                        if (brk && en_tx) begin
                            bits_reg <= char_bits - `SAT_ONE_CNT;
                        end else begin
                            state_reg <= SAT_IDLE;
                            // a high slot lets the next start be seen
                            tail_high_reg <= 1'b1;
                            out_reg <= 1'b1;
                        end
                    end else begin
                        bits_reg <= bits_reg - `SAT_ONE_CNT;
                    end
                end
                default: state_reg <= SAT_IDLE;
            endcase
        end
    end
    // ************************************************************
    // completion flag: idle, nothing buffered, no break or preamble
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            done_reg <= 1'b1;
        end else begin
            done_reg <= (state_reg == SAT_IDLE) && !data_full_reg
                        && !queue_idle_reg && !brk;
        end
    end
    // ************************************************************
    // read port
    // ************************************************************
    // only the two transmitter flags are defined in the status word
    always_comb begin
        status_word = `SAT_RST_BYTE;
        status_word[`SAT_S1_EMPTY] = empty_reg;
        status_word[`SAT_S1_DONE] = done_reg;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= `SAT_RST_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                `SAT_OFS_CTRL_ONE: rdata_reg <= ctrl1_reg;
                `SAT_OFS_CTRL_TWO: rdata_reg <= ctrl2_reg;
                `SAT_OFS_CTRL_THREE: rdata_reg <= ctrl3_reg;
                `SAT_OFS_BAUD: rdata_reg <= baud_reg;
                `SAT_OFS_SYSCFG_TWO: rdata_reg <= syscfg_reg;
                `SAT_OFS_STATUS_ONE: rdata_reg <= status_word;
                default: rdata_reg <= `SAT_RST_BYTE;
            endcase
        end else begin
            rdata_reg <= `SAT_RST_BYTE;
        end
    end
    assign o_rdata = rdata_reg;
    // ************************************************************
    // interrupt request and transmit pin
    // ************************************************************
    // inversion sits after the shifter so idle, break, start and stop all
    // flip; the pin is handed back by dropping both the output enable and the ownership flag
    assign o_tx_irq = (empty_reg && ctrl2_reg[`SAT_C2_TXIE])
                    || (done_reg && ctrl2_reg[`SAT_C2_TX_COMPLETE_IRQ_ENABLE]);
    assign o_serial_out_pin = out_reg ^ inv;
    assign o_serial_out_oe = en_mod;
    assign o_pin_owned = en_mod;
    assign o_rx_enable = en_mod;
endmodule // sat_tx

// ---- sat_consts.svh ----
// register offsets, field positions and reset values of the transmitter
`ifndef SAT_CONSTS_SVH
`define SAT_CONSTS_SVH
// ************************************************************
// register offsets
// ************************************************************
`define SAT_OFS_CTRL_ONE 8'h13
`define SAT_OFS_CTRL_TWO 8'h14
`define SAT_OFS_CTRL_THREE 8'h15
`define SAT_OFS_STATUS_ONE 8'h16
`define SAT_OFS_DATA 8'h18
`define SAT_OFS_BAUD 8'h19
`define SAT_OFS_SYSCFG_TWO 8'h1e
// ************************************************************
// field positions
// ************************************************************
`define SAT_C1_LEN9 4
`define SAT_C1_ENABLE 6
`define SAT_C1_INVERT 5
`define SAT_C2_TXIE 7
`define SAT_C2_TX_COMPLETE_IRQ_ENABLE 6
`define SAT_C2_TXEN 3
`define SAT_C2_BREAK 0
`define SAT_C3_NINTH 6
`define SAT_S1_EMPTY 7
`define SAT_S1_DONE 6
`define SAT_CFG_BAUDSRC 0
// ************************************************************
// reset values and widths
// ************************************************************
`define SAT_RST_BYTE 8'h00
`define SAT_RST_STATUS 8'hc0
`define SAT_BAUD_SEL_W 5
`define SAT_BAUD_CNT_W 16
`define SAT_FRAME_W 11
`define SAT_ONE_CNT 4'h1
`define SAT_CHAR_BITS_8 4'h9
`define SAT_CHAR_BITS_9 4'ha
`endif

// ---- sat_pkg.sv ----
// types shared by the transmitter modules
package sat_pkg;
    typedef enum logic [1:0] {
        SAT_IDLE,
        SAT_PREAMBLE,
        SAT_SHIFT,
        SAT_BREAK
    } sat_state_t;
    typedef logic [7:0] sat_byte_t;
endpackage

// ---- sat_baud_if.sv ----
// baud tick link between the rate generator and the shifter
`timescale 1ns/1ns
interface sat_baud_if;
    logic [4:0] rate_sel;
    logic src_sel;
    logic tick;
    modport gen (input rate_sel, input src_sel, output tick);
    modport user (output rate_sel, output src_sel, input tick);
endinterface

// ---- sat_baud_gen.sv ----
// common baud rate generator with 32 selectable rates
`timescale 1ns/1ns
`include "sat_consts.svh"
module sat_baud_gen #(
    parameter int BASE_DIV = 68
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ext_clk,
    sat_baud_if.gen bif
);
    import sat_pkg::*;
    initial begin
        if (BASE_DIV < 1) $error("sat_baud_gen: BASE_DIV must be >= 1");
        if (BASE_DIV * 64 > (1 << `SAT_BAUD_CNT_W)) begin
            $error("sat_baud_gen: BASE_DIV too large for the counter");
        end
    end
    logic [`SAT_BAUD_CNT_W-1:0] cnt_reg;
    logic [2:0] ext_sync_reg;
    logic [`SAT_BAUD_CNT_W-1:0] limit;
    logic [2:0] pre;
    logic [1:0] exp2;
    logic src_edge;
    // ************************************************************
    // rate: low two bits pick prescale exponent, high three a multiplier
    // ************************************************************
    always_comb begin
        exp2 = bif.rate_sel[1:0];
        pre = bif.rate_sel[4:2];
        limit = `SAT_BAUD_CNT_W'(((BASE_DIV * (int'(pre) + 1)) << exp2) - 1);
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_sync_reg <= 3'h0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], i_ext_clk};
        end
    end
    // external source counts rising edges seen by the last two stages
    assign src_edge = bif.src_sel ? (ext_sync_reg[1] & ~ext_sync_reg[2])
                                  : 1'b1;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else if (src_edge) begin
            cnt_reg <= (cnt_reg >= limit) ? '0 : cnt_reg + 1'b1;
        end
    end
    assign bif.tick = src_edge && (cnt_reg >= limit);
endmodule // sat_baud_gen

// ---- sat_tx_asserts.sv ----
// port-level checker for the serial transmitter
`timescale 1ns/1ns
`include "sat_consts.svh"
module sat_tx_asserts #(
    parameter int BASE_DIV = 68
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire sat_pkg::sat_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire sat_pkg::sat_byte_t o_rdata,
    input wire logic o_serial_out_pin,
    input wire logic o_serial_out_oe,
    input wire logic o_pin_owned,
    input wire logic o_rx_enable,
    input wire logic o_tx_irq
);
    import sat_pkg::*;
    logic txie_q, tx_complete_irq_enable_q, inv_q, pin_d;
    logic [7:0] run_cnt;
    // shadows of the enables, taken on the same edge as the design
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            txie_q <= 1'b0;
            tx_complete_irq_enable_q <= 1'b0;
        end else if (i_wr && i_addr == `SAT_OFS_CTRL_TWO) begin
            txie_q <= i_wdata[`SAT_C2_TXIE];
            tx_complete_irq_enable_q <= i_wdata[`SAT_C2_TX_COMPLETE_IRQ_ENABLE];
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            inv_q <= 1'b0;
        end else if (i_wr && i_addr == `SAT_OFS_CTRL_ONE) begin
            inv_q <= i_wdata[`SAT_C1_INVERT];
        end
    end
    // cycles since the line last moved; saturates so it never wraps
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_d <= 1'b1;
            run_cnt <= 8'h00;
        end else begin
            pin_d <= o_serial_out_pin;
            if (o_serial_out_pin != pin_d) begin
                run_cnt <= 8'h00;
            end else if (run_cnt != 8'hff) begin
                run_cnt <= run_cnt + 8'h01;
            end
        end
    end
    // ********
    // assertions
    // ********
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_oe_owned: assert property (o_pin_owned == o_serial_out_oe)
        else $error("pin ownership differs from output enable");
    a_rx_follow: assert property (o_rx_enable == o_serial_out_oe)
        else $error("receiver enable differs from module enable");
    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read answer cycle");
    a_data_wronly: assert property ((i_rd && i_addr == `SAT_OFS_DATA)
        |=> o_rdata == 8'h00) else $error("data buffer read back");
    a_enable_grab: assert property ((i_wr && i_addr == `SAT_OFS_CTRL_ONE
        && i_wdata[`SAT_C1_ENABLE]) |-> ##[1:2] o_serial_out_oe)
        else $error("pin not taken after enable");
    a_enable_drop: assert property ((i_wr && i_addr == `SAT_OFS_CTRL_ONE
        && !i_wdata[`SAT_C1_ENABLE]) |-> ##[1:2] !o_serial_out_oe)
        else $error("pin not released after disable");
    a_irq_masked: assert property (!txie_q && !tx_complete_irq_enable_q
        && $past(!txie_q && !tx_complete_irq_enable_q) |-> !o_tx_irq)
        else $error("interrupt while both enables clear");
    a_irq_cause: assert property ($rose(o_tx_irq) |-> txie_q || tx_complete_irq_enable_q)
        else $error("interrupt rose without an enable");
    a_idle_high: assert property (!o_serial_out_oe && $past(!o_serial_out_oe)
        && !inv_q |-> o_serial_out_pin) else $error("line not idle high");
    a_bit_width: assert property ((o_serial_out_pin != pin_d) && $stable(inv_q)
        && $past(inv_q, 2) == inv_q && $past(inv_q, 3) == inv_q
        |-> run_cnt >= BASE_DIV - 1) else $error("bit shorter than one period");
    c_data_write: cover property (i_wr && i_addr == `SAT_OFS_DATA);
    c_irq_rise: cover property ($rose(o_tx_irq));
    c_start_edge: cover property ($fell(o_serial_out_pin) && o_serial_out_oe);
endmodule // sat_tx_asserts

// ---- sat_rx_model.sv ----
// far-end receiver model that frames bits off the serial line
`timescale 1ns/1ns
module sat_rx_model (
    input wire logic i_clk,
    input wire logic i_line,
    input wire logic i_nine,
    input wire logic i_inv,
    input wire logic [7:0] i_bit_clks,
    output logic [10:0] o_frame,
    output logic [7:0] o_count
);
    // a start must still be low at mid-bit, so polarity glitches are dropped
    initial begin
        o_frame = 11'h000;
        o_count = 8'h00;
        forever begin
            @(posedge i_clk);
            if (!(i_line ^ i_inv)) begin
                repeat (i_bit_clks / 2) @(posedge i_clk);
                if (!(i_line ^ i_inv)) begin
                    o_frame = 11'h000;
                    for (int i = 0; i < (i_nine ? 11 : 10); i++) begin
                        o_frame[i] = i_line ^ i_inv;
                        if (i < (i_nine ? 10 : 9)) begin
                            repeat (i_bit_clks) @(posedge i_clk);
                        end
                    end
                    o_count = o_count + 8'h01;
                end
            end
        end
    end
endmodule // sat_rx_model

// ---- sat_tx_tb.sv ----
// self-checking testbench of the serial transmitter
`timescale 1ns/1ns
`include "sat_consts.svh"
module sat_tx_tb;
    import sat_pkg::*;
    localparam int DIV = 4;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    sat_byte_t i_wdata = 8'h00;
    sat_byte_t o_rdata, s;
    logic pin, oe, own, rxen, irq;
    logic nine = 1'b0;
    logic inv = 1'b0;
    logic ext_clk = 1'b0;
    logic [10:0] frame;
    logic [7:0] cnt, c;
    int bclk = DIV;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    always #4 i_clk = ~i_clk;
    // external baud source at half the clock rate, changed after each edge
    always @(posedge i_clk) ext_clk <= ~ext_clk;
    sat_tx #(.BASE_DIV(DIV)) i_sat_tx (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_ext_baud_clk(ext_clk), .o_serial_out_pin(pin),
        .o_serial_out_oe(oe), .o_pin_owned(own), .o_rx_enable(rxen),
        .o_tx_irq(irq));
    sat_rx_model i_sat_rx_model (.i_clk(i_clk), .i_line(pin), .i_nine(nine),
        .i_inv(inv), .i_bit_clks(8'(bclk)), .o_frame(frame), .o_count(cnt));
    task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // the ceiling is several times the length of the whole sequence
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic idle(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, sat_byte_t d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 s = o_rdata;
    endtask
    task automatic wait_rx(logic [7:0] c0);
        for (int n = 0; n < 800 && cnt == c0; n++) idle(1);
    endtask
    task automatic send(sat_byte_t b, logic [10:0] exp);
        logic [7:0] c0;
        int n;
        rd(`SAT_OFS_STATUS_ONE);
        wr(`SAT_OFS_DATA, b);
        c0 = cnt;
        rd(`SAT_OFS_STATUS_ONE);
        chk("empty flag", 11'h0, 11'(s[7]));
        for (n = 0; n < 400 && (pin ^ inv); n++) idle(1);
        chk("preamble", 11'h1, 11'(n >= 9 * bclk - 4));
        wait_rx(c0);
        chk("frame", exp, frame);
        rd(`SAT_OFS_STATUS_ONE);
        chk("empty flag", 11'h1, 11'(s[7]));
    endtask
    task automatic t_reset_refuse;
        idle(1);
        chk("idle line", 11'h1, 11'(pin));
        rd(`SAT_OFS_DATA);
        chk("data readback", 11'h0, 11'(s));
        wr(`SAT_OFS_CTRL_ONE, 8'h40);
        wr(`SAT_OFS_CTRL_TWO, 8'h08);
        idle(2);
        chk("pin owned", 11'h3, {own, oe});
        chk("rx enable", 11'h1, 11'(rxen));
        c = cnt;
        wr(`SAT_OFS_DATA, 8'h77);
        idle(20 * DIV);
        chk("unarmed write", 11'(c), 11'(cnt));
        rd(`SAT_OFS_STATUS_ONE);
        chk("status", 11'h0c0, 11'(s));
    endtask
    task automatic t_frames;
        send(8'h5a, {2'b01, 8'h5a, 1'b0});
        wr(`SAT_OFS_BAUD, 8'h05);
        bclk = 4 * DIV;
        send(8'h01, {2'b01, 8'h01, 1'b0});
        wr(`SAT_OFS_BAUD, 8'h00);
        bclk = DIV;
        wr(`SAT_OFS_SYSCFG_TWO, 8'h01);
        bclk = 2 * DIV;
        send(8'ha5, {2'b01, 8'ha5, 1'b0});
        wr(`SAT_OFS_SYSCFG_TWO, 8'h00);
        bclk = DIV;
        wr(`SAT_OFS_CTRL_ONE, 8'h50);
        wr(`SAT_OFS_CTRL_THREE, 8'h40);
        nine = 1'b1;
        send(8'h3c, {2'b11, 8'h3c, 1'b0});
        wr(`SAT_OFS_CTRL_THREE, 8'h00);
        send(8'hc3, {2'b10, 8'hc3, 1'b0});
        wr(`SAT_OFS_CTRL_ONE, 8'h40);
        nine = 1'b0;
    endtask
    task automatic t_irq;
        wr(`SAT_OFS_CTRL_TWO, 8'h88);
        idle(2);
        chk("irq empty", 11'h1, 11'(irq));
        rd(`SAT_OFS_STATUS_ONE);
        wr(`SAT_OFS_DATA, 8'h96);
        c = cnt;
        idle(1);
        chk("irq busy", 11'h0, 11'(irq));
        wait_rx(c);
        chk("irq reload", 11'h1, 11'(irq));
        wr(`SAT_OFS_CTRL_TWO, 8'h48);
        idle(2 * DIV);
        chk("irq complete", 11'h1, 11'(irq));
        wr(`SAT_OFS_CTRL_TWO, 8'h08);
        idle(2);
        chk("irq masked", 11'h0, 11'(irq));
    endtask
    task automatic t_queue_idle;
        rd(`SAT_OFS_STATUS_ONE);
        wr(`SAT_OFS_DATA, 8'h3e);
        c = cnt;
        for (int n = 0; n < 200 && pin; n++) idle(1);
        wr(`SAT_OFS_CTRL_TWO, 8'h00);
        wr(`SAT_OFS_CTRL_TWO, 8'h08);
        wait_rx(c);
        chk("frame", {2'b01, 8'h3e, 1'b0}, frame);
        idle(DIV);
        rd(`SAT_OFS_STATUS_ONE);
        chk("idle queued", 11'h0, 11'(s[6]));
        idle(12 * DIV);
        rd(`SAT_OFS_STATUS_ONE);
        chk("idle sent", 11'h1, 11'(s[6]));
    endtask
    task automatic t_invert_break;
        wr(`SAT_OFS_CTRL_ONE, 8'h60);
        inv = 1'b1;
        idle(4);
        chk("inverted idle", 11'h0, 11'(pin));
        send(8'h81, {2'b01, 8'h81, 1'b0});
        wr(`SAT_OFS_CTRL_ONE, 8'h40);
        inv = 1'b0;
        wr(`SAT_OFS_CTRL_TWO, 8'h09);
        idle(24 * DIV);
        chk("break low", 11'h0, 11'(pin));
        wr(`SAT_OFS_CTRL_TWO, 8'h08);
        idle(14 * DIV);
        chk("break tail", 11'h1, 11'(pin));
        wr(`SAT_OFS_CTRL_ONE, 8'h00);
        idle(2);
        chk("pin released", 11'h0, {own, oe});
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset_refuse();
        t_frames();
        t_irq();
        t_queue_idle();
        t_invert_break();
        conclude();
    end
endmodule // sat_tx_tb
bind sat_tx sat_tx_asserts #(.BASE_DIV(BASE_DIV)) i_sat_tx_asserts (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_serial_out_pin(o_serial_out_pin), .o_serial_out_oe(o_serial_out_oe),
    .o_pin_owned(o_pin_owned), .o_rx_enable(o_rx_enable), .o_tx_irq(o_tx_irq));
